// ---- logic/sfu_pkg.sv ----
/*
  Package for the partial-fetch and partial-update control block:
  register offsets, field positions, reset values and sizes.
  Assumes a 32-bit APB register bus with word-aligned byte addresses.
*/
package sfu_pkg;
  localparam int NUM_PLANES  = 2;
  localparam int NUM_SRC     = NUM_PLANES + 1;  // planes, then the pointer
  localparam int NUM_SETS    = 2;               // 0 regular, 1 partial
  localparam int COORD_W     = 13;
  localparam int CTL_W       = 8;
  localparam int ADDR_W      = 12;
  localparam int GROUP_LINES = 4;

  // global registers
  localparam logic [ADDR_W-1:0] MTC_OFFSET    = 12'h000;
  localparam logic [ADDR_W-1:0] REGION_OFFSET = 12'h004;
  localparam logic [ADDR_W-1:0] SRV2_OFFSET   = 12'h008;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h00c;
  localparam logic [ADDR_W-1:0] PUSH_OFFSET   = 12'h010;
  localparam logic [ADDR_W-1:0] VACT_OFFSET   = 12'h014;
  // per-source block: base + index * stride
  localparam logic [ADDR_W-1:0] SRC_BASE      = 12'h040;
  localparam logic [ADDR_W-1:0] SRC_STRIDE    = 12'h020;
  localparam logic [ADDR_W-1:0] REG_CTL_OFS   = 12'h000;
  localparam logic [ADDR_W-1:0] REG_POS_OFS   = 12'h004;
  localparam logic [ADDR_W-1:0] REG_OFF_OFS   = 12'h008;
  localparam logic [ADDR_W-1:0] PART_CTL_OFS  = 12'h00c;
  localparam logic [ADDR_W-1:0] PART_POS_OFS  = 12'h010;
  localparam logic [ADDR_W-1:0] PART_OFF_OFS  = 12'h014;

  // manual tracking control fields
  localparam int MTC_PFE_BIT   = 0;
  localparam int MTC_MTE_BIT   = 1;
  localparam int MTC_ONE_BIT   = 2;
  localparam int MTC_STICK_BIT = 3;
  localparam int MTC_GRAN_BIT  = 4;
  localparam int MTC_STALL_BIT = 5;
  // region and position words: low field [12:0], high field [28:16]
  localparam int LO_POS = 0;
  localparam int HI_POS = 16;
  localparam int CTL_STALL_BIT = 7;

  localparam logic [COORD_W-1:0] VACT_RESET = 13'h0438;
  localparam logic [CTL_W-1:0]   CTL_RESET  = 8'h00;
  localparam logic [COORD_W-1:0] COORD_RESET = 13'h0000;
endpackage

// ---- logic/sfu_top.sv ----
/*
  Partial-fetch / partial-update control: double-buffered regular and
  partial register sets per plane and pointer, per-frame set choice,
  one-shot and sticky full-frame handling, update region alignment.
  Assumes FRAME_START, FLIP and SR_EXIT come from logic on SYS_CLK.
*/
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - last programmed region wins, no merging
// - second register set per plane and pointer
// - hardware picks register set every frame
// - both sets commit on the same arm
// - region used only when full-frame bits clear
// - region granularity four lines or one line
// - one-shot full-frame bit self-clears after frame
// - sticky bit forces full frames until cleared
// - full-frame bits never start a frame themselves
// - full frames use regular set, whole region
// - self-refresh exit sends one frame unprompted, full unless a commit lands on the same frame start
// - all pending set and region values commit atomically, stall bits exist
module sfu_top
  import sfu_pkg::*;
(
  input  wire logic                                      SYS_CLK,
  input  wire logic                                      RESETN,
  input  wire logic                                      CE,
  input  wire logic                                      PSEL,
  input  wire logic                                      PENABLE,
  input  wire logic                                      PWRITE,
  input  wire logic [sfu_pkg::ADDR_W-1:0]                PADDR,
  input  wire logic [31:0]                               PWDATA,
  output logic      [31:0]                               PRDATA,
  output logic                                           PREADY,
  output logic                                           PSLVERR,
  input  wire logic                                      FRAME_START,
  input  wire logic                                      FLIP,
  input  wire logic                                      SR_EXIT,
  output logic                                           FRAME_SEND,
  output logic                                           FRAME_FULL,
  output logic      [sfu_pkg::COORD_W-1:0]               REGION_FIRST,
  output logic      [sfu_pkg::COORD_W-1:0]               REGION_LAST,
  output logic                                           SRV2_ENABLE,
  output logic [sfu_pkg::NUM_SRC-1:0][sfu_pkg::CTL_W-1:0]   FETCH_CTL,
  output logic [sfu_pkg::NUM_SRC-1:0][sfu_pkg::COORD_W-1:0] FETCH_YPOS,
  output logic [sfu_pkg::NUM_SRC-1:0][sfu_pkg::COORD_W-1:0] FETCH_HEIGHT,
  output logic [sfu_pkg::NUM_SRC-1:0][sfu_pkg::COORD_W-1:0] FETCH_YOFFSET
);
  import sfu_pkg::*;

  localparam int NUM_ENT = NUM_SETS * NUM_SRC;

  //////////////////////////////////////////////////////////////////////////////
  // state

  logic [CTL_W-1:0]   pend_ctl  [NUM_ENT];
  logic [COORD_W-1:0] pend_ypos [NUM_ENT];
  logic [COORD_W-1:0] pend_hgt  [NUM_ENT];
  logic [COORD_W-1:0] pend_yoff [NUM_ENT];
  logic [CTL_W-1:0]   act_ctl   [NUM_ENT];
  logic [COORD_W-1:0] act_ypos  [NUM_ENT];
  logic [COORD_W-1:0] act_hgt   [NUM_ENT];
  logic [COORD_W-1:0] act_yoff  [NUM_ENT];
  logic [CTL_W-1:0]   next_pend_ctl  [NUM_ENT];
  logic [COORD_W-1:0] next_pend_ypos [NUM_ENT];
  logic [COORD_W-1:0] next_pend_hgt  [NUM_ENT];
  logic [COORD_W-1:0] next_pend_yoff [NUM_ENT];
  logic [CTL_W-1:0]   next_act_ctl   [NUM_ENT];
  logic [COORD_W-1:0] next_act_ypos  [NUM_ENT];
  logic [COORD_W-1:0] next_act_hgt   [NUM_ENT];
  logic [COORD_W-1:0] next_act_yoff  [NUM_ENT];

  logic               pfe, mte, one_shot, sticky, gran4, mtc_stall;
  logic               next_pfe, next_mte, next_one_shot, next_sticky;
  logic               next_gran4, next_mtc_stall;
  logic [COORD_W-1:0] pend_first, pend_last, act_first, act_last, vact;
  logic [COORD_W-1:0] next_pend_first, next_pend_last, next_act_first;
  logic [COORD_W-1:0] next_act_last, next_vact;
  logic               act_gran4, next_act_gran4;
  logic               armed, next_armed, exit_pend, next_exit_pend;
  logic               srv2, next_srv2;
  logic               last_full, next_last_full;

  logic [31:0]        next_prdata;
  logic               next_pready, next_pslverr, next_frame_send, next_frame_full;
  logic [COORD_W-1:0] next_region_first, next_region_last;
  logic [NUM_SRC-1:0][CTL_W-1:0]   next_fetch_ctl;
  logic [NUM_SRC-1:0][COORD_W-1:0] next_fetch_ypos, next_fetch_hgt, next_fetch_yoff;

  //////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // which source block an address falls in, NUM_SRC when none
  function automatic int src_of(input logic [ADDR_W-1:0] a);
    int s;
    s = NUM_SRC;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (a >= SRC_BASE + ADDR_W'(i) * SRC_STRIDE &&
          a <  SRC_BASE + ADDR_W'(i + 1) * SRC_STRIDE) begin
        s = i;
      end
    end
    return s;
  endfunction

  function automatic logic [31:0] pack2(input logic [COORD_W-1:0] lo,
                                        input logic [COORD_W-1:0] hi);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[LO_POS +: COORD_W] = lo;
    w[HI_POS +: COORD_W] = hi;
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic              acc, wr, rd, stall, send, full, commit;
    int                s;
    logic [ADDR_W-1:0] rel;
    int                ent;
    logic [31:0]       rdata;
    logic              hit;
    acc   = 1'b0;
    wr    = 1'b0;
    rd    = 1'b0;
    stall = 1'b0;
    send  = 1'b0;
    full  = 1'b0;
    commit = 1'b0;
    s     = 0;
    rel   = '0;
    ent   = 0;
    rdata = 32'h0000_0000;
    hit   = 1'b0;

    next_pend_ctl  = pend_ctl;
    next_pend_ypos = pend_ypos;
    next_pend_hgt  = pend_hgt;
    next_pend_yoff = pend_yoff;
    next_act_ctl   = act_ctl;
    next_act_ypos  = act_ypos;
    next_act_hgt   = act_hgt;
    next_act_yoff  = act_yoff;
    next_pfe = pfe;
    next_mte = mte;
    next_one_shot = one_shot;
    next_sticky = sticky;
    next_gran4 = gran4;
    next_mtc_stall = mtc_stall;
    next_pend_first = pend_first;
    next_pend_last = pend_last;
    next_act_first = act_first;
    next_act_last = act_last;
    next_act_gran4 = act_gran4;
    next_vact = vact;
    next_armed = armed;
    next_exit_pend = exit_pend;
    next_srv2 = srv2;
    next_last_full = last_full;
    next_prdata = PRDATA;
    next_pslverr = 1'b0;
    next_frame_send = 1'b0;
    next_frame_full = FRAME_FULL;
    next_region_first = REGION_FIRST;
    next_region_last = REGION_LAST;
    next_fetch_ctl = FETCH_CTL;
    next_fetch_ypos = FETCH_YPOS;
    next_fetch_hgt = FETCH_HEIGHT;
    next_fetch_yoff = FETCH_YOFFSET;

    // frame event; the full-frame bits alone never start one
    stall = mtc_stall;
    for (int i = 0; i < NUM_SRC; i++) begin
      stall = stall | pend_ctl[i][CTL_STALL_BIT];
    end
    commit = FRAME_START && armed && !stall;
    send   = FRAME_START && ((armed && !stall) || exit_pend);
    full   = one_shot || sticky || !pfe || (exit_pend && !commit);

    // one atomic copy of every pending value, both sets and region
    if (commit) begin
      next_act_ctl   = pend_ctl;
      next_act_ypos  = pend_ypos;
      next_act_hgt   = pend_hgt;
      next_act_yoff  = pend_yoff;
      next_act_first = pend_first;
      next_act_last  = pend_last;
      next_act_gran4 = gran4;
      next_armed     = 1'b0;
    end

    if (send) begin
      next_frame_send = 1'b1;
      next_frame_full = full;
      next_last_full  = full;
      next_exit_pend  = 1'b0;
      for (int i = 0; i < NUM_SRC; i++) begin
        ent = full ? i : NUM_SRC + i;
        next_fetch_ctl[i]  = next_act_ctl[ent];
        next_fetch_ypos[i] = next_act_ypos[ent];
        next_fetch_hgt[i]  = next_act_hgt[ent];
        next_fetch_yoff[i] = next_act_yoff[ent];
      end
      if (full) begin
        next_region_first = '0;
        next_region_last  = vact - COORD_W'(1);
      end else if (next_act_gran4) begin
        // block addresses, last block covers its whole group
        next_region_first = COORD_W'(next_act_first * GROUP_LINES);
        next_region_last  = COORD_W'(next_act_last * GROUP_LINES + GROUP_LINES - 1);
      end else begin
        next_region_first = next_act_first;
        next_region_last  = next_act_last;
      end
      if (one_shot) begin
        next_one_shot = 1'b0;
      end
    end

    if (SR_EXIT) begin
      next_exit_pend = 1'b1;
    end
    if (FLIP) begin
      next_armed = 1'b1;
    end

    // apb: one wait state, writes land on the pready edge
    acc = PSEL && PENABLE;
    next_pready = acc && !PREADY;
    wr  = acc && PREADY && PWRITE;
    rd  = acc && !PREADY && !PWRITE;
    s   = src_of(PADDR);
    rel = PADDR - SRC_BASE - ADDR_W'(s) * SRC_STRIDE;

    if (PADDR[1:0] == 2'b00) begin
      unique case (PADDR)
        MTC_OFFSET: begin
          hit = 1'b1;
          rdata[MTC_PFE_BIT]   = pfe;
          rdata[MTC_MTE_BIT]   = mte;
          rdata[MTC_ONE_BIT]   = one_shot;
          rdata[MTC_STICK_BIT] = sticky;
          rdata[MTC_GRAN_BIT]  = gran4;
          rdata[MTC_STALL_BIT] = mtc_stall;
        end
        REGION_OFFSET: begin
          hit = 1'b1;
          rdata = pack2(pend_first, pend_last);
        end
        SRV2_OFFSET: begin
          hit = 1'b1;
          rdata[0] = srv2;
        end
        STATUS_OFFSET: begin
          hit = 1'b1;
          rdata[0] = armed;
          rdata[1] = exit_pend;
          rdata[2] = last_full;
          rdata[3] = stall;
        end
        PUSH_OFFSET: begin
          hit = 1'b1;
        end
        VACT_OFFSET: begin
          hit = 1'b1;
          rdata[LO_POS +: COORD_W] = vact;
        end
        default: begin
          if (s < NUM_SRC && rel <= PART_OFF_OFS) begin
            hit = 1'b1;
            ent = (rel >= PART_CTL_OFS) ? NUM_SRC + s : s;
            unique case (rel)
              REG_CTL_OFS, PART_CTL_OFS: rdata[CTL_W-1:0] = pend_ctl[ent];
              REG_POS_OFS, PART_POS_OFS: rdata = pack2(pend_ypos[ent], pend_hgt[ent]);
              REG_OFF_OFS, PART_OFF_OFS: rdata[LO_POS +: COORD_W] = pend_yoff[ent];
              default: hit = 1'b0;
            endcase
          end
        end
      endcase
    end

    if (rd) begin
      next_prdata  = hit ? rdata : 32'h0000_0000;
      next_pslverr = !hit;
    end
    if (acc && !PREADY && PWRITE) begin
      next_pslverr = !hit;
    end

    if (wr && hit) begin
      unique case (PADDR)
        MTC_OFFSET: begin
          next_pfe       = PWDATA[MTC_PFE_BIT];
          next_mte       = PWDATA[MTC_MTE_BIT];
          next_one_shot  = PWDATA[MTC_ONE_BIT];                    // set wins over self-clear
          next_sticky    = PWDATA[MTC_STICK_BIT];
          next_gran4     = PWDATA[MTC_GRAN_BIT];
          next_mtc_stall = PWDATA[MTC_STALL_BIT];
        end
        REGION_OFFSET: begin
          next_pend_first = PWDATA[LO_POS +: COORD_W];
          next_pend_last  = PWDATA[HI_POS +: COORD_W];
        end
        SRV2_OFFSET: next_srv2 = PWDATA[0];
        PUSH_OFFSET: begin
          if (PWDATA[0]) begin
            next_armed = 1'b1;
          end
        end
        VACT_OFFSET: next_vact = PWDATA[LO_POS +: COORD_W];
        STATUS_OFFSET: begin
        end
        default: begin
          ent = (rel >= PART_CTL_OFS) ? NUM_SRC + s : s;
          unique case (rel)
            REG_CTL_OFS, PART_CTL_OFS: next_pend_ctl[ent] = PWDATA[CTL_W-1:0];
            REG_POS_OFS, PART_POS_OFS: begin
              next_pend_ypos[ent] = PWDATA[LO_POS +: COORD_W];
              next_pend_hgt[ent]  = PWDATA[HI_POS +: COORD_W];
            end
            default: next_pend_yoff[ent] = PWDATA[LO_POS +: COORD_W];
          endcase
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      for (int i = 0; i < NUM_ENT; i++) begin
        pend_ctl[i]  <= CTL_RESET;
        pend_ypos[i] <= COORD_RESET;
        pend_hgt[i]  <= COORD_RESET;
        pend_yoff[i] <= COORD_RESET;
        act_ctl[i]   <= CTL_RESET;
        act_ypos[i]  <= COORD_RESET;
        act_hgt[i]   <= COORD_RESET;
        act_yoff[i]  <= COORD_RESET;
      end
      {pfe, mte, one_shot, sticky, gran4, mtc_stall} <= 6'h00;
      pend_first <= COORD_RESET;
      pend_last  <= COORD_RESET;
      act_first  <= COORD_RESET;
      act_last   <= COORD_RESET;
      act_gran4  <= 1'b0;
      vact       <= VACT_RESET;
      {armed, exit_pend, srv2, last_full} <= 4'h0;
      PRDATA        <= 32'h0000_0000;
      PREADY        <= 1'b0;
      PSLVERR       <= 1'b0;
      FRAME_SEND    <= 1'b0;
      FRAME_FULL    <= 1'b0;
      REGION_FIRST  <= COORD_RESET;
      REGION_LAST   <= COORD_RESET;
      FETCH_CTL     <= '0;
      FETCH_YPOS    <= '0;
      FETCH_HEIGHT  <= '0;
      FETCH_YOFFSET <= '0;
    end else if (CE) begin
      pend_ctl  <= next_pend_ctl;
      pend_ypos <= next_pend_ypos;
      pend_hgt  <= next_pend_hgt;
      pend_yoff <= next_pend_yoff;
      act_ctl   <= next_act_ctl;
      act_ypos  <= next_act_ypos;
      act_hgt   <= next_act_hgt;
      act_yoff  <= next_act_yoff;
      {pfe, mte, one_shot, sticky, gran4, mtc_stall} <=
        {next_pfe, next_mte, next_one_shot, next_sticky, next_gran4, next_mtc_stall};
      pend_first <= next_pend_first;
      pend_last  <= next_pend_last;
      act_first  <= next_act_first;
      act_last   <= next_act_last;
      act_gran4  <= next_act_gran4;
      vact       <= next_vact;
      {armed, exit_pend, srv2, last_full} <=
        {next_armed, next_exit_pend, next_srv2, next_last_full};
      PRDATA        <= next_prdata;
      PREADY        <= next_pready;
      PSLVERR       <= next_pslverr;
      FRAME_SEND    <= next_frame_send;
      FRAME_FULL    <= next_frame_full;
      REGION_FIRST  <= next_region_first;
      REGION_LAST   <= next_region_last;
      FETCH_CTL     <= next_fetch_ctl;
      FETCH_YPOS    <= next_fetch_ypos;
      FETCH_HEIGHT  <= next_fetch_hgt;
      FETCH_YOFFSET <= next_fetch_yoff;
    end
  end

  assign SRV2_ENABLE = srv2;

endmodule

`default_nettype wire

// ---- tb/sfu_checker.sv ----
/*
  Concurrent checks on the partial-update control block's ports.
  Assumes CE stays high, one SYS_CLK domain, RESETN sync active low.
*/
`timescale 1ns/100ps
`default_nettype none
module sfu_checker
  import sfu_pkg::*;
(
  input wire logic                                       SYS_CLK,
  input wire logic                                       RESETN,
  input wire logic                                       PSEL,
  input wire logic                                       PENABLE,
  input wire logic                                       PWRITE,
  input wire logic [sfu_pkg::ADDR_W-1:0]                 PADDR,
  input wire logic [31:0]                                PRDATA,
  input wire logic                                       PREADY,
  input wire logic                                       PSLVERR,
  input wire logic                                       FRAME_START,
  input wire logic                                       FRAME_SEND,
  input wire logic                                       FRAME_FULL,
  input wire logic [sfu_pkg::COORD_W-1:0]                REGION_FIRST,
  input wire logic                                       SRV2_ENABLE,
  input wire logic [sfu_pkg::NUM_SRC-1:0][sfu_pkg::CTL_W-1:0]   FETCH_CTL,
  input wire logic [sfu_pkg::NUM_SRC-1:0][sfu_pkg::COORD_W-1:0] FETCH_YPOS
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////
  property p_send_start;
    FRAME_SEND |-> $past(FRAME_START);
  endproperty
  a_send_start: assert property (p_send_start) else $error("send without frame start");
  property p_full_region;
    FRAME_SEND && FRAME_FULL |-> REGION_FIRST == '0;
  endproperty
  a_full_region: assert property (p_full_region) else $error("full frame region");
  // guard on past reset: outputs drop to zero at the last reset edge
  property p_hold;
    !FRAME_SEND && $past(RESETN) |-> $stable(FETCH_CTL) && $stable(FETCH_YPOS)
      && $stable(FRAME_FULL) && $stable(REGION_FIRST);
  endproperty
  a_hold: assert property (p_hold) else $error("fetch set moved between frames");
  property p_pready_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("ready longer than a cycle");
  property p_pready_wait;
    PSEL && PENABLE && !PREADY |=> PREADY;
  endproperty
  a_pready_wait: assert property (p_pready_wait) else $error("ready late");
  property p_err_ready;
    PSLVERR |-> PREADY;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_err_rdata;
    PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0;
  endproperty
  a_err_rdata: assert property (p_err_rdata) else $error("error read data not zero");
  property p_srv2;
    $past(RESETN) && SRV2_ENABLE != $past(SRV2_ENABLE)
      |-> $past(PSEL) && $past(PREADY) && $past(PWRITE) && $past(PADDR) == SRV2_OFFSET;
  endproperty
  a_srv2: assert property (p_srv2) else $error("self refresh enable moved alone");
  c_part: cover property (FRAME_SEND && !FRAME_FULL);
  c_full: cover property (FRAME_SEND && FRAME_FULL);
  c_err: cover property (PREADY && PSLVERR);
endmodule
bind sfu_top sfu_checker u_chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .FRAME_START(FRAME_START), .FRAME_SEND(FRAME_SEND),
  .FRAME_FULL(FRAME_FULL), .REGION_FIRST(REGION_FIRST), .SRV2_ENABLE(SRV2_ENABLE),
  .FETCH_CTL(FETCH_CTL), .FETCH_YPOS(FETCH_YPOS));
`default_nettype wire

// ---- tb/sfu_panel.sv ----
/*
  Panel with remote frame buffer: counts frames and lines received.
  Assumes the region outputs are settled whenever FRAME_SEND is high.
*/
`timescale 1ns/100ps
`default_nettype none
module sfu_panel (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic        FRAME_SEND,
  input  wire logic [12:0] REGION_FIRST,
  input  wire logic [12:0] REGION_LAST,
  output logic      [15:0] frame_count,
  output logic      [12:0] line_count
);
  logic [15:0] next_frame_count;
  logic [12:0] next_line_count;
  ////////////////////////////////////////
  // one rectangle per frame, always full width, so lines are all we keep
  always_comb begin
    next_frame_count = frame_count;
    next_line_count  = line_count;
    if (FRAME_SEND) begin
      next_frame_count = frame_count + 16'h0001;
      next_line_count  = REGION_LAST - REGION_FIRST + 13'h0001;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      frame_count <= 16'h0000;
      line_count  <= 13'h0000;
    end else begin
      frame_count <= next_frame_count;
      line_count  <= next_line_count;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
/*
  Self-checking bench: APB master, frame timing and software sequences.
  Assumes the offsets and field positions of sfu_pkg.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sfu_pkg::*;
  logic                            SYS_CLK, RESETN, CE, PSEL, PENABLE, PWRITE;
  logic                            FRAME_START, FLIP, SR_EXIT, PREADY, PSLVERR;
  logic                            FRAME_SEND, FRAME_FULL, SRV2_ENABLE, err;
  logic [ADDR_W-1:0]               PADDR;
  logic [31:0]                     PWDATA, PRDATA, rd;
  logic [COORD_W-1:0]              REGION_FIRST, REGION_LAST;
  logic [NUM_SRC-1:0][CTL_W-1:0]   FETCH_CTL;
  logic [NUM_SRC-1:0][COORD_W-1:0] FETCH_YPOS, FETCH_HEIGHT, FETCH_YOFFSET;
  logic [15:0]                     frame_count;
  logic [12:0]                     line_count;
  int                              fails, check_count;
  sfu_top uut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FRAME_START(FRAME_START), .FLIP(FLIP), .SR_EXIT(SR_EXIT),
    .FRAME_SEND(FRAME_SEND), .FRAME_FULL(FRAME_FULL), .REGION_FIRST(REGION_FIRST),
    .REGION_LAST(REGION_LAST), .SRV2_ENABLE(SRV2_ENABLE), .FETCH_CTL(FETCH_CTL),
    .FETCH_YPOS(FETCH_YPOS), .FETCH_HEIGHT(FETCH_HEIGHT), .FETCH_YOFFSET(FETCH_YOFFSET));
  sfu_panel u_panel (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .FRAME_SEND(FRAME_SEND),
    .REGION_FIRST(REGION_FIRST), .REGION_LAST(REGION_LAST), .frame_count(frame_count),
    .line_count(line_count));
  ////////////////////////////////////////
  task automatic give_verdict;
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // request held until ready is sampled high, released only after that edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    // only the watchdog ends a wait that never sees ready
    do begin
      @(posedge SYS_CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic flip;
    @(posedge SYS_CLK);
    FLIP <= 1'b1;
    @(posedge SYS_CLK);
    FLIP <= 1'b0;
  endtask
  task automatic frame(input logic exp_send);
    @(posedge SYS_CLK);
    FRAME_START <= 1'b1;
    @(posedge SYS_CLK);
    FRAME_START <= 1'b0;
    @(posedge SYS_CLK);
    chk(FRAME_SEND, exp_send);
  endtask
  task automatic chk_set(input logic part);
    for (int i = 0; i < NUM_SRC; i++) begin
      chk(FETCH_CTL[i], part ? 32'h01 + i : 32'h11 + i);
      chk(FETCH_YPOS[i], part ? 32'h200 + i : 32'h010 * i);
      chk(FETCH_HEIGHT[i], part ? 32'h008 + i : 32'h100 + i);
      chk(FETCH_YOFFSET[i], part ? 32'h300 + i : 32'h020 + i);
    end
  endtask
  task automatic chk_frame(input logic full, input logic [31:0] f, input logic [31:0] l);
    chk(FRAME_FULL, full);
    chk(REGION_FIRST, f);
    chk(REGION_LAST, l);
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    apb(1'b0, VACT_OFFSET, 32'h0);
    chk(rd, 32'h438);
    apb(1'b0, 12'h030, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h002, 32'h5);
    chk(err, 1'b1);
    wr(MTC_OFFSET, 32'h3);
    wr(SRV2_OFFSET, 32'h1);
    @(posedge SYS_CLK);
    chk(SRV2_ENABLE, 1'b1);
  endtask
  task automatic t_partial;
    logic [ADDR_W-1:0] b;
    for (int i = 0; i < NUM_SRC; i++) begin
      b = SRC_BASE + SRC_STRIDE * ADDR_W'(i);
      wr(b + REG_CTL_OFS, 32'h11 + i);
      wr(b + REG_POS_OFS, ((32'h100 + i) << 16) | (32'h010 * i));
      wr(b + REG_OFF_OFS, 32'h020 + i);
      wr(b + PART_CTL_OFS, 32'h01 + i);
      wr(b + PART_POS_OFS, ((32'h008 + i) << 16) | (32'h200 + i));
      wr(b + PART_OFF_OFS, 32'h300 + i);
    end
    wr(MTC_OFFSET, 32'h1);
    wr(REGION_OFFSET, 32'h003f0010);
    wr(REGION_OFFSET, 32'h005f0040);
    frame(1'b0);
    chk(FETCH_CTL[0], 32'h0);
    flip();
    frame(1'b1);
    chk_frame(1'b0, 32'h040, 32'h05f);
    chk_set(1'b1);
    @(posedge SYS_CLK);
    chk(line_count, 32'h20);
  endtask
  task automatic t_one_shot;
    wr(MTC_OFFSET, 32'h5);
    frame(1'b0);
    flip();
    frame(1'b1);
    chk_frame(1'b1, 32'h0, 32'h437);
    chk_set(1'b0);
    apb(1'b0, MTC_OFFSET, 32'h0);
    chk(rd, 32'h1);
    flip();
    frame(1'b1);
    chk(FRAME_FULL, 1'b0);
  endtask
  task automatic t_sticky;
    wr(MTC_OFFSET, 32'hd);
    for (int k = 0; k < 2; k++) begin
      flip();
      frame(1'b1);
      chk(FRAME_FULL, 1'b1);
    end
    apb(1'b0, MTC_OFFSET, 32'h0);
    chk(rd, 32'h9);
    wr(MTC_OFFSET, 32'h1);
    flip();
    frame(1'b1);
    chk(FRAME_FULL, 1'b0);
  endtask
  task automatic t_gran;
    wr(REGION_OFFSET, 32'h00030002);
    wr(MTC_OFFSET, 32'h11);
    flip();
    frame(1'b1);
    chk_frame(1'b0, 32'h008, 32'h00f);
  endtask
  task automatic t_stall;
    wr(MTC_OFFSET, 32'h21);
    wr(PUSH_OFFSET, 32'h1);
    frame(1'b0);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'h9);
    wr(MTC_OFFSET, 32'h1);
    frame(1'b1);
    chk_frame(1'b0, 32'h040, 32'h05f);
  endtask
  task automatic t_exit;
    @(posedge SYS_CLK);
    SR_EXIT <= 1'b1;
    @(posedge SYS_CLK);
    SR_EXIT <= 1'b0;
    frame(1'b1);
    chk_frame(1'b1, 32'h0, 32'h437);
    chk_set(1'b0);
    @(posedge SYS_CLK);
    chk(frame_count, 32'h9);
  endtask
  ////////////////////////////////////////
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  // whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    fails++;
    give_verdict();
  end
  initial begin
    {RESETN, PSEL, PENABLE, PWRITE, FRAME_START, FLIP, SR_EXIT} = 7'h00;
    CE = 1'b1;
    PADDR = '0;
    PWDATA = 32'h0;
    fails = 0;
    check_count = 0;
    repeat (3) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    t_regs();
    t_partial();
    t_one_shot();
    t_sticky();
    t_gran();
    wr(REGION_OFFSET, 32'h005f0040);
    t_stall();
    t_exit();
    give_verdict();
  end
endmodule
`default_nettype wire
